// ==== logic/bkr5_pkg.sv ====
// constants shared by the rail-five configuration bank
package bkr5_pkg;
  // register pointer values on the serial bus
  localparam logic [7:0] REG_NORMAL = 8'h00;
  localparam logic [7:0] REG_LOWPWR = 8'h01;
  localparam logic [7:0] REG_UPDLY  = 8'h02;
  localparam logic [7:0] REG_DNDLY  = 8'h03;
  localparam logic [7:0] REG_RAMP   = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h05;
  // reset values
  localparam logic [7:0] RST_NORMAL = 8'h00;
  localparam logic [7:0] RST_LOWPWR = 8'h00;
  localparam logic [7:0] RST_UPDLY  = 8'h0f;
  localparam logic [7:0] RST_DNDLY  = 8'h00;
  localparam logic [7:0] RST_RAMP   = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  // writable bits; unused bits read zero, except config bits 1:0, which are kept
  localparam logic [7:0] MSK_SETTING = 8'h1f;
  localparam logic [7:0] MSK_DELAY   = 8'h7f;
  localparam logic [7:0] MSK_RAMP    = 8'hff;
  localparam logic [7:0] MSK_CONFIG  = 8'h7f;
  // field positions (low bit of each field)
  localparam int F_MODE   = 3;
  localparam int F_VOLT   = 0;
  localparam int F_START  = 6;
  localparam int F_STOP   = 4;
  localparam int F_RISE   = 2;
  localparam int F_FALL   = 0;
  localparam int F_PHASE  = 5;
  localparam int F_FREQ   = 2;
  // shutdown option code that skips the shutdown wait
  localparam logic [1:0] STOP_OPT_SKIP = 2'h3;
  // phase offset while synchronisation is off
  localparam logic [1:0] PHASE_NONE = 2'h0;
  // ramp/stop code 00 = 4 ms = eight half-ms units, halved per code step
  localparam logic [7:0] PERIOD_MAX_HALF_MS = 8'h08;
  // serial device address, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2a;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int HALF_MS_NS    = 'h0007_a120;
endpackage : bkr5_pkg

// ==== logic/bkr5_regbus_if.sv ====
// internal register access between serial engine and bank
`timescale 1ns/10ps
`default_nettype none
interface bkr5_regbus_if;
  logic       wr_stb;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport master (output wr_stb, output waddr, output wdata, output raddr, input rdata);
  modport slave  (input wr_stb, input waddr, input wdata, input raddr, output rdata);
endinterface : bkr5_regbus_if
`default_nettype wire

// ==== logic/bkr5_serial_slave.sv ====
// two-wire serial slave driving the register bus
`timescale 1ns/10ps
`default_nettype none
module bkr5_serial_slave (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_oe,
  bkr5_regbus_if.master    bus
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_RX   = 6'b00_0010,
    ST_ACK  = 6'b00_0100,
    ST_TX   = 6'b00_1000,
    ST_RACK = 6'b01_0000,
    ST_LOAD = 6'b10_0000
  } bkr5_ser_e;

  logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
  bkr5_ser_e state, next_state;
  logic [2:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg, ptr, next_ptr, wdata, next_wdata, waddr, next_waddr;
  logic [1:0] byte_no, next_byte_no;
  logic       rw, next_rw, sda_oe, next_sda_oe, wr_stb, next_wr_stb;
  logic       scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0] rx_byte;

  // two-stage synchronisers plus one history stage
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      {scl_s1, scl_s2, scl_q} <= 3'h7;
      {sda_s1, sda_s2, sda_q} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_q} <= {i_scl, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_q} <= {i_sda, sda_s1, sda_s2};
    end
  end

  assign scl_rise   = scl_s2 & ~scl_q;
  assign scl_fall   = ~scl_s2 & scl_q;
  assign start_cond = scl_s2 & scl_q & sda_q & ~sda_s2;
  assign stop_cond  = scl_s2 & scl_q & ~sda_q & sda_s2;
  assign rx_byte    = {shreg[6:0], sda_s2};

  // byte engine: address, pointer, then data with auto-increment
  always_comb begin
    next_state   = state;
    next_bitcnt  = bitcnt;
    next_shreg   = shreg;
    next_ptr     = ptr;
    next_byte_no = byte_no;
    next_rw      = rw;
    next_sda_oe  = sda_oe;
    next_wr_stb  = 1'b0;
    next_wdata   = wdata;
    next_waddr   = waddr;
    if (start_cond) begin
      next_state   = ST_RX;
      next_bitcnt  = 3'h0;
      next_byte_no = 2'h0;
      next_sda_oe  = 1'b0;
    end else if (stop_cond) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: ;
        ST_RX: if (scl_rise) begin
          next_shreg  = rx_byte;
          next_bitcnt = bitcnt + 3'h1;
          if (bitcnt == 3'h7) begin
            next_state = ST_ACK;
            if (byte_no != 2'h2) next_byte_no = byte_no + 2'h1;
            if (byte_no == 2'h0) begin
              next_rw = rx_byte[0];
              if (rx_byte[7:1] != bkr5_pkg::DEV_ADDR) next_state = ST_IDLE;
            end else if (byte_no == 2'h1 && !rw) begin
              next_ptr = rx_byte;
            end else begin
              next_wr_stb = 1'b1;
              next_wdata  = rx_byte;
              next_waddr  = ptr;
              next_ptr    = ptr + 8'h01;
            end
          end
        end
        ST_ACK: if (scl_fall) begin
          if (!sda_oe) begin
            next_sda_oe = 1'b1;           // pull low for acknowledge
          end else if (rw) begin
            next_shreg  = bus.rdata;
            next_sda_oe = ~bus.rdata[7];
            next_bitcnt = 3'h0;
            next_state  = ST_TX;
          end else begin
            next_sda_oe = 1'b0;
            next_bitcnt = 3'h0;
            next_state  = ST_RX;
          end
        end
        ST_TX: if (scl_fall) begin
          if (bitcnt == 3'h7) begin
            next_sda_oe = 1'b0;
            next_state  = ST_RACK;
          end else begin
            next_bitcnt = bitcnt + 3'h1;
            next_shreg  = {shreg[6:0], 1'b0};
            next_sda_oe = ~shreg[6];
          end
        end
        ST_RACK: if (scl_rise) begin
          if (sda_s2) begin
            next_state = ST_IDLE;         // master ends the read
          end else begin
            next_ptr   = ptr + 8'h01;
            next_state = ST_LOAD;
          end
        end
        ST_LOAD: if (scl_fall) begin
          next_shreg  = bus.rdata;
          next_sda_oe = ~bus.rdata[7];
          next_bitcnt = 3'h0;
          next_state  = ST_TX;
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state   <= ST_IDLE;
      bitcnt  <= 3'h0;
      shreg   <= 8'h00;
      ptr     <= 8'h00;
      byte_no <= 2'h0;
      rw      <= 1'b0;
      sda_oe  <= 1'b0;
      wr_stb  <= 1'b0;
      wdata   <= 8'h00;
      waddr   <= 8'h00;
    end else begin
      state   <= next_state;
      bitcnt  <= next_bitcnt;
      shreg   <= next_shreg;
      ptr     <= next_ptr;
      byte_no <= next_byte_no;
      rw      <= next_rw;
      sda_oe  <= next_sda_oe;
      wr_stb  <= next_wr_stb;
      wdata   <= next_wdata;
      waddr   <= next_waddr;
    end
  end

  assign o_sda_oe   = sda_oe;
  assign bus.wr_stb = wr_stb;
  assign bus.waddr  = waddr;
  assign bus.wdata  = wdata;
  assign bus.raddr  = ptr;
endmodule : bkr5_serial_slave
`default_nettype wire

// ==== logic/bkr5_config_bank.sv ====
// rail-five configuration registers and shutdown sequencing
`timescale 1ns/10ps
`default_nettype none
module bkr5_config_bank #(
  parameter int P_HALF_MS_CYCLES = bkr5_pkg::HALF_MS_NS / bkr5_pkg::CLK_PERIOD_NS
) (
  input  wire logic       I_CLK,
  input  wire logic       I_RESET,
  input  wire logic       I_SCL,
  input  wire logic       I_SDA,
  input  wire logic       I_CHIP_ENABLE,
  input  wire logic       I_LOW_POWER,
  input  wire logic       I_LAST_RAIL_OFF,
  input  wire logic       I_RAIL1_PHASE_LOCK_EN,
  input  wire logic [1:0] I_STOP_OPTION,
  output logic            O_SDA,
  output logic            O_SDA_OE,
  output logic            O_RAIL_ON,
  output logic            O_RAMPING,
  output logic [1:0]      O_MODE_SEL,
  output logic [2:0]      O_VOLTAGE_CODE,
  output logic [1:0]      O_RAMP_START_TIME,
  output logic [1:0]      O_RISE_SLEW_SEL,
  output logic [1:0]      O_FALL_SLEW_SEL,
  output logic [1:0]      O_PHASE_OFFSET_SEL,
  output logic [2:0]      O_SWITCH_FREQ_SEL,
  output logic            O_STANDBY,
  output logic            O_SEQ_IN_RESET
);
  typedef enum logic [7:0] {
    ST_RESET   = 8'b0000_0001,
    ST_UP_WAIT = 8'b0000_0010,
    ST_RAMP    = 8'b0000_0100,
    ST_ON      = 8'b0000_1000,
    ST_DN_WAIT = 8'b0001_0000,
    ST_LAST    = 8'b0010_0000,
    ST_STOP    = 8'b0100_0000,
    ST_STANDBY = 8'b1000_0000
  } bkr5_seq_e;

  localparam logic [15:0] PRE_LAST = 16'(P_HALF_MS_CYCLES - 1);

  bkr5_regbus_if regbus ();

  // register file
  logic [7:0] rail5_normal_state_setting, next_rail5_normal_state_setting;
  logic [7:0] rail5_low_power_setting, next_rail5_low_power_setting;
  logic [7:0] rail5_power_up_delay, next_rail5_power_up_delay;
  logic [7:0] rail5_power_down_delay, next_rail5_power_down_delay;
  logic [7:0] rail5_ramp_timing, next_rail5_ramp_timing;
  logic [7:0] rail5_switching_config, next_rail5_switching_config;
  logic [7:0] rdata;

  // field views
  logic [1:0] rail5_normal_mode_sel, rail5_low_power_mode_sel;
  logic [2:0] rail5_normal_voltage_code, rail5_low_power_voltage_code;
  logic [6:0] rail5_up_delay_ms, rail5_down_delay_ms;
  logic [1:0] rail5_ramp_start_time, rail5_stop_wait_time;
  logic [1:0] rail5_rise_slew_sel, rail5_fall_slew_sel;
  logic [1:0] rail5_phase_offset_sel;
  logic [2:0] rail5_switch_freq_sel;

  // pin synchronisers
  logic ce_s1, ce_s2, lp_s1, lp_s2;

  // sequencer
  bkr5_seq_e  state, next_state;
  logic [15:0] pre, next_pre;
  logic [7:0]  tcnt, next_tcnt;
  logic        tick, tdone;

  // outputs
  logic       next_rail_on, next_ramping, next_standby, next_in_reset;
  logic [1:0] next_mode, next_start, next_rise, next_fall, next_phase;
  logic [2:0] next_volt, next_freq;

  bkr5_serial_slave u_serial (
    .i_clk    (I_CLK),
    .i_reset  (I_RESET),
    .i_scl    (I_SCL),
    .i_sda    (I_SDA),
    .o_sda_oe (O_SDA_OE),
    .bus      (regbus.master)
  );

  // field extraction
  assign rail5_normal_mode_sel        = rail5_normal_state_setting[bkr5_pkg::F_MODE +: 2];
  assign rail5_normal_voltage_code    = rail5_normal_state_setting[bkr5_pkg::F_VOLT +: 3];
  assign rail5_low_power_mode_sel     = rail5_low_power_setting[bkr5_pkg::F_MODE +: 2];
  assign rail5_low_power_voltage_code = rail5_low_power_setting[bkr5_pkg::F_VOLT +: 3];
  assign rail5_up_delay_ms            = rail5_power_up_delay[6:0];
  assign rail5_down_delay_ms          = rail5_power_down_delay[6:0];
  assign rail5_ramp_start_time        = rail5_ramp_timing[bkr5_pkg::F_START +: 2];
  assign rail5_stop_wait_time         = rail5_ramp_timing[bkr5_pkg::F_STOP +: 2];
  assign rail5_rise_slew_sel          = rail5_ramp_timing[bkr5_pkg::F_RISE +: 2];
  assign rail5_fall_slew_sel          = rail5_ramp_timing[bkr5_pkg::F_FALL +: 2];
  assign rail5_phase_offset_sel       = rail5_switching_config[bkr5_pkg::F_PHASE +: 2];
  assign rail5_switch_freq_sel        = rail5_switching_config[bkr5_pkg::F_FREQ +: 3];

  // register writes, unused bits masked off except config bits 1:0
  always_comb begin
    next_rail5_normal_state_setting = rail5_normal_state_setting;
    next_rail5_low_power_setting    = rail5_low_power_setting;
    next_rail5_power_up_delay       = rail5_power_up_delay;
    next_rail5_power_down_delay     = rail5_power_down_delay;
    next_rail5_ramp_timing          = rail5_ramp_timing;
    next_rail5_switching_config     = rail5_switching_config;
    if (regbus.wr_stb) begin
      unique case (regbus.waddr)
        bkr5_pkg::REG_NORMAL: next_rail5_normal_state_setting = regbus.wdata & bkr5_pkg::MSK_SETTING;
        bkr5_pkg::REG_LOWPWR: next_rail5_low_power_setting = regbus.wdata & bkr5_pkg::MSK_SETTING;
        bkr5_pkg::REG_UPDLY:  next_rail5_power_up_delay = regbus.wdata & bkr5_pkg::MSK_DELAY;
        bkr5_pkg::REG_DNDLY:  next_rail5_power_down_delay = regbus.wdata & bkr5_pkg::MSK_DELAY;
        bkr5_pkg::REG_RAMP:   next_rail5_ramp_timing = regbus.wdata & bkr5_pkg::MSK_RAMP;
        bkr5_pkg::REG_CONFIG: next_rail5_switching_config = regbus.wdata & bkr5_pkg::MSK_CONFIG;
        default: ;                        // unmapped pointer, write dropped
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      rail5_normal_state_setting <= bkr5_pkg::RST_NORMAL;
      rail5_low_power_setting    <= bkr5_pkg::RST_LOWPWR;
      rail5_power_up_delay       <= bkr5_pkg::RST_UPDLY;
      rail5_power_down_delay     <= bkr5_pkg::RST_DNDLY;
      rail5_ramp_timing          <= bkr5_pkg::RST_RAMP;
      rail5_switching_config     <= bkr5_pkg::RST_CONFIG;
    end else begin
      rail5_normal_state_setting <= next_rail5_normal_state_setting;
      rail5_low_power_setting    <= next_rail5_low_power_setting;
      rail5_power_up_delay       <= next_rail5_power_up_delay;
      rail5_power_down_delay     <= next_rail5_power_down_delay;
      rail5_ramp_timing          <= next_rail5_ramp_timing;
      rail5_switching_config     <= next_rail5_switching_config;
    end
  end

  // read decode; unmapped pointers read zero
  always_comb begin
    unique case (regbus.raddr)
      bkr5_pkg::REG_NORMAL: rdata = rail5_normal_state_setting;
      bkr5_pkg::REG_LOWPWR: rdata = rail5_low_power_setting;
      bkr5_pkg::REG_UPDLY:  rdata = rail5_power_up_delay;
      bkr5_pkg::REG_DNDLY:  rdata = rail5_power_down_delay;
      bkr5_pkg::REG_RAMP:   rdata = rail5_ramp_timing;
      bkr5_pkg::REG_CONFIG: rdata = rail5_switching_config;
      default:              rdata = 8'h00;
    endcase
  end
  assign regbus.rdata = rdata;

  // enable and low-power pins cross into the clock domain
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      {ce_s1, ce_s2} <= 2'h0;
      {lp_s1, lp_s2} <= 2'h0;
    end else begin
      {ce_s1, ce_s2} <= {I_CHIP_ENABLE, ce_s1};
      {lp_s1, lp_s2} <= {I_LOW_POWER, lp_s1};
    end
  end

  // half-millisecond timebase, restarted whenever a period is loaded
  assign tick  = (pre == PRE_LAST);
  assign tdone = (tcnt == 8'h00);

  // power sequencing state machine
  always_comb begin
    next_state = state;
    next_pre   = tick ? 16'h0000 : pre + 16'h0001;
    next_tcnt  = (tick && !tdone) ? tcnt - 8'h01 : tcnt;
    unique case (state)
      ST_RESET: if (ce_s2) begin
        next_state = ST_UP_WAIT;
        next_tcnt  = {rail5_up_delay_ms, 1'b0};
        next_pre   = 16'h0000;
      end
      ST_UP_WAIT: begin
        if (!ce_s2) begin
          next_state = ST_RESET;
        end else if (tdone) begin
          next_state = ST_RAMP;
          next_tcnt  = bkr5_pkg::PERIOD_MAX_HALF_MS >> rail5_ramp_start_time;
          next_pre   = 16'h0000;
        end
      end
      ST_RAMP, ST_ON: begin
        if (!ce_s2) begin
          next_state = ST_DN_WAIT;
          next_tcnt  = {rail5_down_delay_ms, 1'b0};
          next_pre   = 16'h0000;
        end else if (state == ST_RAMP && tdone) begin
          next_state = ST_ON;
        end
      end
      ST_DN_WAIT: if (tdone) begin
        // skip the wait when the shutdown option disables it
        next_state = (I_STOP_OPTION == bkr5_pkg::STOP_OPT_SKIP) ? ST_STANDBY : ST_LAST;
      end
      ST_LAST: if (I_LAST_RAIL_OFF) begin
        next_state = ST_STOP;
        next_tcnt  = bkr5_pkg::PERIOD_MAX_HALF_MS >> rail5_stop_wait_time;
        next_pre   = 16'h0000;
      end
      ST_STOP:    if (tdone) next_state = ST_STANDBY;
      ST_STANDBY: next_state = ST_RESET;
      default:    next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state <= ST_RESET;
      pre   <= 16'h0000;
      tcnt  <= 8'h00;
    end else begin
      state <= next_state;
      pre   <= next_pre;
      tcnt  <= next_tcnt;
    end
  end

  // settings handed to the regulator; mode and voltage picked per power state
  always_comb begin
    // rail stays up through the down delay, drops only when it has run out
    next_rail_on  = (next_state == ST_RAMP) || (next_state == ST_ON) || (next_state == ST_DN_WAIT);
    next_ramping  = (next_state == ST_RAMP);
    next_standby  = (next_state == ST_STANDBY);
    next_in_reset = (next_state == ST_RESET);
    if (lp_s2) begin
      next_mode = rail5_low_power_mode_sel;
      next_volt = rail5_low_power_voltage_code;
    end else begin
      next_mode = rail5_normal_mode_sel;
      next_volt = rail5_normal_voltage_code;
    end
    next_start = rail5_ramp_start_time;
    next_rise  = rail5_rise_slew_sel;
    next_fall  = rail5_fall_slew_sel;
    next_phase = I_RAIL1_PHASE_LOCK_EN ? rail5_phase_offset_sel : bkr5_pkg::PHASE_NONE;
    next_freq  = rail5_switch_freq_sel;
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_SDA              <= 1'b0;                 // open drain, only ever low
      O_RAIL_ON          <= 1'b0;
      O_RAMPING          <= 1'b0;
      O_STANDBY          <= 1'b0;
      O_SEQ_IN_RESET     <= 1'b1;
      O_MODE_SEL         <= 2'h0;
      O_VOLTAGE_CODE     <= 3'h0;
      O_RAMP_START_TIME  <= 2'h0;
      O_RISE_SLEW_SEL    <= 2'h0;
      O_FALL_SLEW_SEL    <= 2'h0;
      O_PHASE_OFFSET_SEL <= 2'h0;
      O_SWITCH_FREQ_SEL  <= 3'h0;
    end else begin
      O_SDA              <= 1'b0;
      O_RAIL_ON          <= next_rail_on;
      O_RAMPING          <= next_ramping;
      O_STANDBY          <= next_standby;
      O_SEQ_IN_RESET     <= next_in_reset;
      O_MODE_SEL         <= next_mode;
      O_VOLTAGE_CODE     <= next_volt;
      O_RAMP_START_TIME  <= next_start;
      O_RISE_SLEW_SEL    <= next_rise;
      O_FALL_SLEW_SEL    <= next_fall;
      O_PHASE_OFFSET_SEL <= next_phase;
      O_SWITCH_FREQ_SEL  <= next_freq;
    end
  end
endmodule : bkr5_config_bank
`default_nettype wire

// ==== dv/bkr5_bank_assertions.sv ====
// concurrent checks on the rail-five bank ports
`timescale 1ns/10ps
`default_nettype none
module bkr5_bank_checker #(
  parameter int P_HALF_MS_CYCLES = 4
) (
  input wire logic       I_CLK,
  input wire logic       I_RESET,
  input wire logic       I_CHIP_ENABLE,
  input wire logic       I_LAST_RAIL_OFF,
  input wire logic       I_RAIL1_PHASE_LOCK_EN,
  input wire logic [1:0] I_STOP_OPTION,
  input wire logic       O_RAIL_ON,
  input wire logic       O_RAMPING,
  input wire logic [1:0] O_PHASE_OFFSET_SEL,
  input wire logic       O_STANDBY,
  input wire logic       O_SEQ_IN_RESET
);
  localparam int RAMP_MAX = 8 * P_HALF_MS_CYCLES + 1;
  int ramp_len;
  // length of the current soft-start run
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ramp_len <= 0;
    end else begin
      ramp_len <= O_RAMPING ? ramp_len + 1 : 0;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  a_phase_gate: assert property (!I_RAIL1_PHASE_LOCK_EN |=> O_PHASE_OFFSET_SEL == 2'h0)
    else $error("phase offset shown while lock is off");
  a_standby_pulse: assert property (O_STANDBY |=> !O_STANDBY)
    else $error("standby lasted more than one cycle");
  a_standby_to_reset: assert property (O_STANDBY |=> O_SEQ_IN_RESET)
    else $error("standby not followed by reset state");
  a_reset_rail_off: assert property (O_SEQ_IN_RESET |-> !O_RAIL_ON && !O_RAMPING)
    else $error("rail on while sequencer in reset");
  a_ramp_rail_on: assert property (O_RAMPING |-> O_RAIL_ON)
    else $error("ramping without rail on");
  a_ramp_max_len: assert property (O_RAMPING |-> ramp_len <= RAMP_MAX)
    else $error("soft-start longer than 4 ms");
  a_wait_last_rail: assert property (O_STANDBY && I_STOP_OPTION != 2'h3 |-> $past(I_LAST_RAIL_OFF, 3))
    else $error("standby before last rail off");
  a_ce_gate: assert property (O_SEQ_IN_RESET && !I_CHIP_ENABLE |=> !O_RAIL_ON [*2])
    else $error("rail on without chip enable");
  a_down_hold: assert property ($fell(I_CHIP_ENABLE) && O_RAIL_ON |=> O_RAIL_ON [*3])
    else $error("rail dropped without down wait");
  c_standby: cover property (O_STANDBY);
  c_ramp: cover property ($rose(O_RAMPING));
  c_phase: cover property (O_PHASE_OFFSET_SEL != 2'h0);
endmodule : bkr5_bank_checker
bind bkr5_config_bank bkr5_bank_checker #(.P_HALF_MS_CYCLES(P_HALF_MS_CYCLES)) u_chk (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_CHIP_ENABLE(I_CHIP_ENABLE), .I_LAST_RAIL_OFF(I_LAST_RAIL_OFF),
  .I_RAIL1_PHASE_LOCK_EN(I_RAIL1_PHASE_LOCK_EN), .I_STOP_OPTION(I_STOP_OPTION), .O_RAIL_ON(O_RAIL_ON),
  .O_RAMPING(O_RAMPING), .O_PHASE_OFFSET_SEL(O_PHASE_OFFSET_SEL), .O_STANDBY(O_STANDBY),
  .O_SEQ_IN_RESET(O_SEQ_IN_RESET));
`default_nettype wire

// ==== dv/bkr5_host_model.sv ====
// two-wire host model driving the bank's serial pins
`timescale 1ns/10ps
`default_nettype none
module bkr5_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output var logic  o_scl,
  output var logic  o_sda_low
);
  int         qtr = 4;
  logic [7:0] nacks = 8'h00;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic gap(input logic scl, input logic low);
    o_scl = scl;
    o_sda_low = low;
    repeat (qtr) @(negedge i_clk);
  endtask : gap
  // one bit: data set while clock low, sampled mid clock-high
  task automatic bit_io(input logic b, output logic r);
    gap(1'b0, !b);
    gap(1'b1, !b);
    r = i_sda;
    gap(1'b1, !b);
    gap(1'b0, !b);
  endtask : bit_io
  // byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, r);
  endtask : xfer
  // start or repeated start, then device address
  task automatic begin_frame(input logic rd);
    logic [7:0] q;
    logic       r;
    gap(1'b0, 1'b0);
    gap(1'b1, 1'b0);
    gap(1'b1, 1'b1);
    xfer({bkr5_pkg::DEV_ADDR, rd}, 1'b1, q, r);
    nacks += {7'h00, r};
  endtask : begin_frame
  task automatic stop_frame();
    gap(1'b0, 1'b1);
    gap(1'b1, 1'b1);
    gap(1'b1, 1'b0);
  endtask : stop_frame
  // codes with zero unused bits are handed, except 45 to pointer 05 (config bit 0 set) and 11 written to unmapped pointer 06
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] q;
    logic       r;
    begin_frame(1'b0);
    xfer(ptr, 1'b1, q, r);
    nacks += {7'h00, r};
    xfer(d, 1'b1, q, r);
    nacks += {7'h00, r};
    stop_frame();
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic r;
    begin_frame(1'b0);
    xfer(ptr, 1'b1, d, r);
    nacks += {7'h00, r};
    begin_frame(1'b1);
    xfer(8'hff, 1'b1, d, r);
    stop_frame();
  endtask : rd_reg
endmodule : bkr5_host_model
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the rail-five configuration bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  localparam int HMS = 4;
  typedef struct packed { logic [7:0] ptr; logic [7:0] wd; logic [7:0] rd; } bkr5_row_s;
  logic clk, reset, ce, lowp, last_off, lock, scl, sda_low, sda_oe, rail_on, ramping, stby, in_rst;
  logic [1:0] stop_opt, mode, rstart, rise, fall, phase;
  logic [2:0] volt, freq;
  logic [7:0] d;
  int         n, num_errors, num_checks, cycles;
  wire logic  sda = !(sda_low || sda_oe);
  logic [7:0] rst_v [6] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00};
  bkr5_row_s rows [10] = '{'{8'h00, 8'h07, 8'h07}, '{8'h01, 8'h0f, 8'h0f}, '{8'h02, 8'h02, 8'h02},
    '{8'h03, 8'h7f, 8'h7f}, '{8'h03, 8'h01, 8'h01}, '{8'h04, 8'h9b, 8'h9b}, '{8'h05, 8'h45, 8'h45},
    '{8'h06, 8'h11, 8'h00}, '{8'h00, 8'h0e, 8'h0e}, '{8'h01, 8'h04, 8'h04}};
  bkr5_config_bank #(.P_HALF_MS_CYCLES(HMS)) dut (.I_CLK(clk), .I_RESET(reset), .I_SCL(scl), .I_SDA(sda),
    .I_CHIP_ENABLE(ce), .I_LOW_POWER(lowp), .I_LAST_RAIL_OFF(last_off), .I_RAIL1_PHASE_LOCK_EN(lock),
    .I_STOP_OPTION(stop_opt), .O_SDA(), .O_SDA_OE(sda_oe), .O_RAIL_ON(rail_on), .O_RAMPING(ramping),
    .O_MODE_SEL(mode), .O_VOLTAGE_CODE(volt), .O_RAMP_START_TIME(rstart), .O_RISE_SLEW_SEL(rise),
    .O_FALL_SLEW_SEL(fall), .O_PHASE_OFFSET_SEL(phase), .O_SWITCH_FREQ_SEL(freq), .O_STANDBY(stby),
    .O_SEQ_IN_RESET(in_rst));
  bkr5_host_model host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic pick(input int w);
    return w == 0 ? rail_on : (w == 1 ? ramping : stby);
  endfunction : pick
  // cycles until the chosen output reaches a level
  task automatic measure(input int w, input logic lvl, output int m);
    m = 0;
    while (pick(w) !== lvl && m < 2000) begin
      @(negedge clk);
      m++;
    end
  endtask : measure
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    {reset, ce, lowp, last_off, lock, stop_opt} = 7'b100_0000;
    repeat (12) @(negedge clk);
    `CHK(in_rst, 1'b1)
    reset = 1'b0;
    for (int i = 0; i < 6; i++) begin
      host.rd_reg(i[7:0], d);
      `CHK(d, rst_v[i])
    end
    // table: write, read back, unmapped place and slow host included
    for (int i = 0; i < 10; i++) begin
      host.qtr = (i == 5) ? 9 : 4;
      host.wr_reg(rows[i].ptr, rows[i].wd);
      host.rd_reg(rows[i].ptr, d);
      `CHK(d, rows[i].rd)
    end
    `CHK(host.nacks, 8'h00)
    `CHK({mode, volt, rstart, rise, fall}, 11'b01_110_10_10_11)
    `CHK({freq, phase}, 5'b001_00)
    {lock, lowp} = 2'b11;
    repeat (6) @(negedge clk);
    `CHK({mode, volt, phase}, 7'b00_100_10)
    {lock, lowp} = 2'b00;
    ce = 1'b1;
    measure(0, 1'b1, n);
    `CHK((n >= 4 * HMS && n <= 4 * HMS + 5) ? 0 : n, 0)
    measure(1, 1'b0, n);
    `CHK((n >= 2 * HMS - 1 && n <= 2 * HMS + 1) ? 0 : n, 0)
    ce = 1'b0;
    measure(0, 1'b0, n);
    `CHK((n >= 2 * HMS && n <= 2 * HMS + 5) ? 0 : n, 0)
    repeat (30) @(negedge clk);
    `CHK(in_rst, 1'b0)
    last_off = 1'b1;
    measure(2, 1'b1, n);
    `CHK((n >= 4 * HMS && n <= 4 * HMS + 3) ? 0 : n, 0)
    @(negedge clk);
    `CHK({stby, in_rst}, 2'b01)
    {last_off, stop_opt, ce} = 4'b0111;
    measure(0, 1'b1, n);
    ce = 1'b0;
    measure(2, 1'b1, n);
    `CHK((n >= 2 * HMS && n <= 2 * HMS + 8) ? 0 : n, 0)
    // keep the skip option until the standby pulse has been sampled
    @(negedge clk);
    {stop_opt, ce} = 3'b001;
    repeat (8) @(negedge clk);
    ce = 1'b0;
    repeat (30) @(negedge clk);
    `CHK({rail_on, in_rst}, 2'b01)
    complete_run();
  end
endmodule : tb
`default_nettype wire
